/* File: hdl/dftr_pkg.sv */
// Shared constants, register map and helper functions of the threshold ramp.
`default_nettype none
package dftr_pkg;

    // ***********************************************************************
    // Timing
    // ***********************************************************************
    localparam int     CLK_KHZ          = 50000;
    localparam int     RAMP_FULL_MS     = 35000;
    localparam int     DUTY_SLOTS       = 255;
    localparam longint RAMP_TICK_L      =
        (longint'(CLK_KHZ) * longint'(RAMP_FULL_MS)) / longint'(DUTY_SLOTS);
    localparam int     RAMP_TICK_CYCLES = int'(RAMP_TICK_L);
    localparam int     SLOW_FACTOR      = 4;

    // ***********************************************************************
    // Register indices (byte address is four times the index)
    // ***********************************************************************
    localparam logic [7:0] IDX_OP_R1     = 8'h33;
    localparam logic [7:0] IDX_OP_R2     = 8'h35;
    localparam logic [7:0] IDX_DYN_CTRL  = 8'h36;
    localparam logic [7:0] IDX_LIM_FIRST = 8'h4E;
    localparam logic [7:0] IDX_LIM_LAST  = 8'h53;
    localparam logic [7:0] IDX_CFG_FIRST = 8'h5C;
    localparam logic [7:0] IDX_CFG_LAST  = 8'h5E;
    localparam logic [7:0] IDX_ACOU1     = 8'h62;
    localparam logic [7:0] IDX_FAN2_STEP_SELECT     = 8'h63;
    localparam logic [7:0] IDX_THR_FIRST = 8'h67;
    localparam logic [7:0] IDX_THR_LAST  = 8'h69;
    localparam logic [7:0] IDX_FMT       = 8'h70;
    localparam logic [7:0] IDX_DUTY_FST  = 8'h71;
    localparam logic [7:0] IDX_DUTY_LST  = 8'h73;
    localparam logic [7:0] IDX_STAT      = 8'h74;

    // ***********************************************************************
    // Field positions, channel order remote 1, local, remote 2
    // ***********************************************************************
    localparam int CAP_BIT   [3] = '{4, 3, 2};
    localparam int DYN_BIT   [3] = '{7, 6, 5};
    localparam int STEP_LSB  [3] = '{0, 4, 0};
    localparam int RAMP_BIT  [3] = '{3, 7, 3};
    localparam int SLOW_BIT      = 3;
    localparam int OFF64_BIT     = 0;

    // ***********************************************************************
    // Reset values
    // ***********************************************************************
    localparam logic [7:0] OP_RST   = 8'hA4;
    localparam logic [7:0] LOW_RST  = 8'h01;
    localparam logic [7:0] HIGH_RST = 8'h7F;
    localparam logic [7:0] THR_RST  = 8'h5A;
    localparam logic [7:0] REG_RST  = 8'h00;

    // ***********************************************************************
    // Temperature format
    // ***********************************************************************
    localparam logic signed [8:0] FLOOR_TWOS  = 9'sh181;
    localparam logic signed [8:0] FLOOR_OFF64 = 9'sh1C0;
    localparam logic        [8:0] TEMP_OFFSET = 9'h040;

    // Step size in time slots for a three-bit ramp code.
    function automatic logic [7:0] step_slots(input logic [2:0] code);
        unique case (code)
            3'h0: step_slots = 8'h01;
            3'h1: step_slots = 8'h02;
            3'h2: step_slots = 8'h03;
            3'h3: step_slots = 8'h05;
            3'h4: step_slots = 8'h08;
            3'h5: step_slots = 8'h0C;
            3'h6: step_slots = 8'h18;
            3'h7: step_slots = 8'h30;
        endcase
    endfunction

    // Raw register value to signed degrees.
    function automatic logic signed [8:0] to_deg(input logic [7:0] v,
                                                 input logic       off64);
        to_deg = off64 ? $signed({1'b0, v} - TEMP_OFFSET)
                       : $signed({v[7], v});
    endfunction

    // Signed degrees back to the raw register value.
    function automatic logic [7:0] from_deg(input logic signed [8:0] d,
                                            input logic              off64);
        logic [8:0] raw;
        raw      = off64 ? 9'($unsigned(d) + TEMP_OFFSET) : $unsigned(d);
        from_deg = raw[7:0];
    endfunction

endpackage
`default_nettype wire

/* File: hdl/dftr_thresh.sv */
// Long-cycle raise and floor clamp of one channel's fan start threshold.
`default_nettype none
module dftr_thresh
    import dftr_pkg::*;
(
    input  wire logic       off64_in,
    input  wire logic       dyn_en_in,
    input  wire logic       long_cycle_in,
    input  wire logic [7:0] temp_in,
    input  wire logic [7:0] low_in,
    input  wire logic [7:0] high_in,
    input  wire logic [7:0] op_in,
    input  wire logic [7:0] thr_in,
    output logic      [7:0] next_thr_out,
    output logic            below_out
);

    logic signed [8:0] t_deg;
    logic signed [8:0] thr_deg;
    logic signed [8:0] floor_deg;
    logic signed [8:0] cand;
    logic              raise;

    always_comb begin
        t_deg     = to_deg(temp_in, off64_in);
        thr_deg   = to_deg(thr_in, off64_in);
        floor_deg = off64_in ? FLOOR_OFF64 : FLOOR_TWOS;
        below_out = t_deg < thr_deg; // [R04]
        raise     = dyn_en_in && long_cycle_in // [R01] [R10] [R23]
                 && !below_out // [R04]
                 && (t_deg < to_deg(low_in, off64_in)) // [R01]
                 && (thr_deg < to_deg(high_in, off64_in)) // [R02]
                 && (thr_deg < to_deg(op_in, off64_in)); // [R03]
        cand = raise ? 9'(thr_deg + 9'sd1) : thr_deg;
        if (dyn_en_in && (cand < floor_deg)) begin
            cand = floor_deg; // [R05]
        end
        next_thr_out = dyn_en_in ? from_deg(cand, off64_in) : thr_in; // [R11]
    end

endmodule // dftr_thresh
`default_nettype wire

/* File: hdl/dftr_ramp.sv */
// Stepped acoustic ramp of one fan drive duty cycle.
`default_nettype none
module dftr_ramp
    import dftr_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       tick_in,
    input  wire logic       ramp_en_in,
    input  wire logic       slow_in,
    input  wire logic [2:0] step_code_in,
    input  wire logic [7:0] target_in,
    output logic      [7:0] duty_out
);

    typedef struct packed {
        logic [7:0] duty;
        logic [1:0] slow_cnt;
    } dftr_ramp_s;

    dftr_ramp_s st;
    dftr_ramp_s next_st;
    logic [7:0] step;
    logic       act;

    always_comb begin
        next_st = st;
        step    = step_slots(step_code_in); // [R12] [R13] [R14]
        act     = tick_in && (!slow_in || (st.slow_cnt == 2'(SLOW_FACTOR - 1)));
        if (tick_in) begin
            next_st.slow_cnt = st.slow_cnt + 2'h1; // [R17] [R22]
        end
        if (!ramp_en_in) begin
            next_st.duty = target_in; // [R21]
        end else if (act && (target_in > st.duty)) begin
            // Keep climbing while the target is above the output. [R16]
            next_st.duty = ((target_in - st.duty) > step)
                         ? 8'(st.duty + step) : target_in; // [R15] [R20]
        end else if (act && (target_in < st.duty)) begin
            next_st.duty = ((st.duty - target_in) > step)
                         ? 8'(st.duty - step) : target_in; // [R19]
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign duty_out = st.duty;

endmodule // dftr_ramp
`default_nettype wire

/* File: hdl/dftr_top.sv */
// Dynamic fan start threshold, alert capture and acoustic ramp with APB.
//
// What this block does
// [R01] Raise threshold on long cycle below low limit
// [R02] Raise only below high limit, never above
// [R03] Raise only while below operating point
// [R04] Below threshold: fan minimum, adjustment suspended; the block only flags it on below_start_out and leaves duty_out untouched
// [R05] Clamp threshold floor per temperature format
// [R06] Remote 2 capture on alert when enabled
// [R07] Local capture on alert when enabled
// [R08] Remote 1 capture on alert when enabled
// [R09] Disabled capture keeps programmed operating point
// [R10] Control bits enable adjustment per channel
// [R11] Disabled adjustment leaves threshold untouched
// [R12] Fan 1 step size select, eight codes
// [R13] Fan 3 step size select, same codes
// [R14] Fan 2 step size select, same codes
// [R15] One-slot full ramp takes about 35 s
// [R16] Keep stepping up while target stays above
// [R17] Optional per-output four times slower ramp
// [R18] Low alert input means capture assertion
// [R19] Step down when target below, store result
// [R20] Drive period has 255 slots
// [R21] Enable bits turn stepped ramping on
// [R22] Configuration bit 3 slows ramp by four
// [R23] Evaluate raise together at long cycle
`default_nettype none
module dftr_top
    import dftr_pkg::*;
#(
    parameter int TICK_CYCLES = RAMP_TICK_CYCLES
)
(
    input  wire logic            core_clk_in,
    input  wire logic            rst_n_in,
    // APB slave.
    input  wire logic            psel_in,
    input  wire logic            penable_in,
    input  wire logic            pwrite_in,
    input  wire logic [9:0]      paddr_in,
    input  wire logic [31:0]     pwdata_in,
    output logic      [31:0]     prdata_out,
    output logic                 pready_out,
    output logic                 pslverr_out,
    // Measurement side, channel order remote 1, local, remote 2.
    input  wire logic [2:0][7:0] temp_in,
    input  wire logic [2:0]      long_cycle_in,
    input  wire logic            overtemp_alert_pin_n_in,
    // Fan side, order fan 1, fan 2, fan 3.
    input  wire logic [2:0][7:0] target_duty_in,
    output logic      [2:0][7:0] duty_out,
    output logic      [2:0]      below_start_out,
    output logic      [2:0][7:0] fan_start_threshold_out
);

    // ***********************************************************************
    // State
    // ***********************************************************************
    typedef struct packed {
        logic [2:0][7:0] op;
        logic [2:0][7:0] low;
        logic [2:0][7:0] high;
        logic [2:0][7:0] thr;
        logic [2:0][7:0] fan_cfg;
        logic [7:0]      dyn_ctrl;
        logic [7:0]      acou1;
        logic [7:0]      fan2_step_select;
        logic [7:0]      fmt;
        logic [31:0]     tick_cnt;
        logic            tick;
        logic            alert_s1;
        logic            alert_s2;
        logic [31:0]     rdata;
        logic            rerr;
    } dftr_top_s;

    dftr_top_s       st;
    dftr_top_s       next_st;
    logic [2:0][7:0] thr_next;
    logic [2:0]      below;
    logic [2:0]      cap_en;
    logic [2:0]      dyn_en;
    logic [2:0][2:0] step_code;
    logic [2:0]      ramp_en;
    logic [2:0]      slow;
    logic            alert_on;
    logic [7:0]      idx;
    logic            setup;
    logic            wr_acc;

    // ***********************************************************************
    // Register decode
    // ***********************************************************************
    // True when the index names an implemented register.
    function automatic logic idx_mapped(input logic [7:0] i);
        idx_mapped = (i >= IDX_OP_R1 && i <= IDX_DYN_CTRL)
                  || (i >= IDX_LIM_FIRST && i <= IDX_LIM_LAST)
                  || (i >= IDX_CFG_FIRST && i <= IDX_CFG_LAST)
                  || (i == IDX_ACOU1) || (i == IDX_FAN2_STEP_SELECT)
                  || (i >= IDX_THR_FIRST && i <= IDX_THR_LAST)
                  || (i >= IDX_FMT && i <= IDX_STAT);
    endfunction

    // Register value seen by a read of the given index.
    function automatic logic [7:0] reg_value(input dftr_top_s       s,
                                             input logic [7:0]      i,
                                             input logic [2:0][7:0] d,
                                             input logic [2:0]      b);
        logic [7:0] k;
        k         = 8'h00;
        reg_value = 8'h00;
        if (i >= IDX_OP_R1 && i <= IDX_OP_R2) begin
            k         = i - IDX_OP_R1;
            reg_value = s.op[k[1:0]];
        end else if (i == IDX_DYN_CTRL) begin
            reg_value = s.dyn_ctrl;
        end else if (i >= IDX_LIM_FIRST && i <= IDX_LIM_LAST) begin
            k         = i - IDX_LIM_FIRST;
            reg_value = k[0] ? s.high[k[2:1]] : s.low[k[2:1]];
        end else if (i >= IDX_CFG_FIRST && i <= IDX_CFG_LAST) begin
            k         = i - IDX_CFG_FIRST;
            reg_value = s.fan_cfg[k[1:0]];
        end else if (i == IDX_ACOU1) begin
            reg_value = s.acou1;
        end else if (i == IDX_FAN2_STEP_SELECT) begin
            reg_value = s.fan2_step_select;
        end else if (i >= IDX_THR_FIRST && i <= IDX_THR_LAST) begin
            k         = i - IDX_THR_FIRST;
            reg_value = s.thr[k[1:0]];
        end else if (i == IDX_FMT) begin
            reg_value = s.fmt;
        end else if (i >= IDX_DUTY_FST && i <= IDX_DUTY_LST) begin
            k         = i - IDX_DUTY_FST;
            reg_value = d[k[1:0]];
        end else if (i == IDX_STAT) begin
            reg_value = {5'h00, b};
        end
    endfunction

    // ***********************************************************************
    // Per-channel and per-fan field extraction
    // ***********************************************************************
    assign alert_on = !st.alert_s2; // [R18]

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_chan
            assign cap_en[g]    = st.dyn_ctrl[CAP_BIT[g]];
            assign dyn_en[g]    = st.dyn_ctrl[DYN_BIT[g]]; // [R10]
            assign step_code[g] = (g == 0)
                ? st.acou1[STEP_LSB[g] +: 3]
                : st.fan2_step_select[STEP_LSB[g] +: 3];
            assign ramp_en[g]   = (g == 0)
                ? st.acou1[RAMP_BIT[g]]
                : st.fan2_step_select[RAMP_BIT[g]]; // [R21]
            assign slow[g]      = st.fan_cfg[g][SLOW_BIT]; // [R22]

            dftr_thresh u_thresh (
                .off64_in      (st.fmt[OFF64_BIT]),
                .dyn_en_in     (dyn_en[g]),
                .long_cycle_in (long_cycle_in[g]),
                .temp_in       (temp_in[g]),
                .low_in        (st.low[g]),
                .high_in       (st.high[g]),
                .op_in         (st.op[g]),
                .thr_in        (st.thr[g]),
                .next_thr_out  (thr_next[g]),
                .below_out     (below[g])
            );

            dftr_ramp u_ramp (
                .core_clk_in  (core_clk_in),
                .rst_n_in     (rst_n_in),
                .tick_in      (st.tick),
                .ramp_en_in   (ramp_en[g]),
                .slow_in      (slow[g]),
                .step_code_in (step_code[g]),
                .target_in    (target_duty_in[g]),
                .duty_out     (duty_out[g])
            );
        end
    endgenerate

    // ***********************************************************************
    // Next state
    // ***********************************************************************
    always_comb begin
        next_st  = st;
        idx      = paddr_in[9:2];
        setup    = psel_in && !penable_in;
        wr_acc   = psel_in && penable_in && pwrite_in;

        // Alert pin synchroniser.
        next_st.alert_s1 = overtemp_alert_pin_n_in;
        next_st.alert_s2 = st.alert_s1;

        // Time base for the duty ramp, one tick per slot step. [R15]
        next_st.tick = 1'b0;
        if (st.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = 32'h0000_0000;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
        end

        // Read data and error are prepared in the setup cycle.
        if (setup) begin
            next_st.rerr  = !idx_mapped(idx) || (paddr_in[1:0] != 2'h0);
            next_st.rdata = next_st.rerr ? 32'h0000_0000
                          : {24'h00_0000, reg_value(st, idx, duty_out,
                                                   below)};
        end

        // Software writes in the access phase.
        if (wr_acc && !st.rerr) begin
            if (idx >= IDX_OP_R1 && idx <= IDX_OP_R2) begin
                next_st.op[2'(idx - IDX_OP_R1)] = pwdata_in[7:0];
            end else if (idx == IDX_DYN_CTRL) begin
                next_st.dyn_ctrl = pwdata_in[7:0];
            end else if (idx >= IDX_LIM_FIRST && idx <= IDX_LIM_LAST) begin
                if (idx[0] == IDX_LIM_FIRST[0]) begin
                    next_st.low[2'((idx - IDX_LIM_FIRST) >> 1)] =
                        pwdata_in[7:0];
                end else begin
                    next_st.high[2'((idx - IDX_LIM_FIRST) >> 1)] =
                        pwdata_in[7:0];
                end
            end else if (idx >= IDX_CFG_FIRST && idx <= IDX_CFG_LAST) begin
                next_st.fan_cfg[2'(idx - IDX_CFG_FIRST)] = pwdata_in[7:0];
            end else if (idx == IDX_ACOU1) begin
                next_st.acou1 = pwdata_in[7:0];
            end else if (idx == IDX_FAN2_STEP_SELECT) begin
                next_st.fan2_step_select = pwdata_in[7:0];
            end else if (idx >= IDX_THR_FIRST && idx <= IDX_THR_LAST) begin
                next_st.thr[2'(idx - IDX_THR_FIRST)] = pwdata_in[7:0];
            end else if (idx == IDX_FMT) begin
                next_st.fmt = pwdata_in[7:0];
            end
        end

        // Hardware updates take priority over a write in the same cycle.
        for (int c = 0; c < 3; c++) begin
            if (dyn_en[c] && (thr_next[c] != st.thr[c])) begin
                next_st.thr[c] = thr_next[c]; // [R01] [R05] [R11]
            end
            if (alert_on && cap_en[c]) begin
                // Capture follows the alert level while it is held.
                next_st.op[c] = temp_in[c]; // [R06] [R07] [R08] [R09]
            end
        end
    end

    // ***********************************************************************
    // Registers
    // ***********************************************************************
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st          <= '0;
            st.op       <= {3{OP_RST}};
            st.low      <= {3{LOW_RST}};
            st.high     <= {3{HIGH_RST}};
            st.thr      <= {3{THR_RST}};
            st.fan_cfg  <= {3{REG_RST}};
            st.dyn_ctrl <= REG_RST;
            st.acou1    <= REG_RST;
            st.fan2_step_select    <= REG_RST;
            st.fmt      <= REG_RST;
            st.alert_s1 <= 1'b1;
            st.alert_s2 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ***********************************************************************
    // Outputs
    // ***********************************************************************
    assign pready_out              = 1'b1;
    assign prdata_out              = st.rdata;
    assign pslverr_out             = psel_in && penable_in && st.rerr;
    assign fan_start_threshold_out = st.thr;
    assign below_start_out         = below; // [R04]

endmodule // dftr_top
`default_nettype wire

/* File: sim/dftr_sva.sv */
// Checker of threshold, ramp and bus behaviour at the top ports.
`default_nettype none
module dftr_sva
    import dftr_pkg::*;
(
    input wire logic            core_clk_in,
    input wire logic            rst_n_in,
    input wire logic            psel_in,
    input wire logic            penable_in,
    input wire logic            pwrite_in,
    input wire logic [9:0]      paddr_in,
    input wire logic [31:0]     prdata_out,
    input wire logic            pready_out,
    input wire logic            pslverr_out,
    input wire logic [2:0][7:0] temp_in,
    input wire logic [2:0]      long_cycle_in,
    input wire logic [2:0][7:0] target_duty_in,
    input wire logic [2:0][7:0] duty_out,
    input wire logic [2:0]      below_start_out,
    input wire logic [2:0][7:0] fan_start_threshold_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wr_acc;
    logic [7:0] thr0;
    logic [7:0] d0;
    logic [7:0] t0;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign thr0   = fan_start_threshold_out[0];
    assign d0     = duty_out[0];
    assign t0     = target_duty_in[0];
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_thr_held_idle: assert property (!$past(long_cycle_in[0]) &&
        !$past(wr_acc) && $past(thr0) != 8'h80 |-> $stable(thr0))
        else $error("threshold moved without cause");
    a_thr_one_step: assert property ($past(long_cycle_in[0]) &&
        !$past(wr_acc) |-> thr0 == $past(thr0) ||
        thr0 == 8'($past(thr0) + 8'h01))
        else $error("threshold step not one");
    a_thr_frozen_below: assert property (long_cycle_in[2] &&
        below_start_out[2] && !wr_acc |=> $stable(fan_start_threshold_out[2]))
        else $error("threshold moved below start");
    a_below_flag: assert property (below_start_out[1] ==
        ($signed(temp_in[1]) < $signed(fan_start_threshold_out[1])))
        else $error("below flag wrong");
    a_ramp_rises: assert property ($past(t0) > $past(d0)
        |-> d0 >= $past(d0))
        else $error("duty fell while target above");
    a_ramp_falls: assert property ($past(t0) < $past(d0)
        |-> d0 <= $past(d0))
        else $error("duty rose while target below");
    a_ramp_no_pass: assert property ($past(t0) >= $past(d0)
        |-> d0 <= $past(t0))
        else $error("duty passed target");
    a_pready_access: assert property (psel_in && penable_in |-> pready_out)
        else $error("no ready in access");
    a_err_access_only: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("error outside access");
    a_err_unmapped: assert property (psel_in && penable_in && !pwrite_in &&
        paddr_in[9:2] == 8'h00 |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped read not refused");
endmodule // dftr_sva
bind dftr_top dftr_sva i_sva (.core_clk_in, .rst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .temp_in,
    .long_cycle_in, .target_duty_in, .duty_out, .below_start_out,
    .fan_start_threshold_out);
`default_nettype wire

/* File: sim/dftr_hot_model.sv */
// Processor hot output that pulls the overtemperature alert line low.
`default_nettype none
module dftr_hot_model (
    input  wire logic hot_in,
    output logic      alert_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // The line has a pull-up, so it sits high while the output is released.
    assign alert_n_out = hot_in ? 1'b0 : 1'b1;
endmodule // dftr_hot_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the threshold ramp block.
`default_nettype none
`define CHK(a, b) begin \
    checks_done++; \
    if ((a) !== (b)) begin \
        bad_count++; \
        $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
    end \
end
module tb
    import dftr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 4;
    localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                         8'h08, 8'h0C, 8'h18, 8'h30};
    logic            clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
    logic            pwr = 1'b0, hot = 1'b0, alert_n, pready, er, perr;
    logic [9:0]      paddr = '0;
    logic [31:0]     pwdata = '0, prdata, rd;
    logic [2:0][7:0] temp = '0, tgt = '0, duty, thr;
    logic [2:0]      lc = '0, below;
    logic [7:0]      e [3], hi [3], op [3], ri, tg;
    int              bad_count = 0, checks_done = 0, cyc = 0, sh, n;

    always #10 clk = ~clk;

    dftr_top #(.TICK_CYCLES(TICK)) i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(perr), .temp_in(temp), .long_cycle_in(lc),
        .overtemp_alert_pin_n_in(alert_n), .target_duty_in(tgt),
        .duty_out(duty), .below_start_out(below),
        .fan_start_threshold_out(thr));
    dftr_hot_model i_hot (.hot_in(hot), .alert_n_out(alert_n));

    task automatic apb(input logic w, input logic [7:0] idx, d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [7:0] up(input logic [7:0] t, tp, h, o);
        up = ($signed(tp) >= $signed(t) && $signed(tp) < $signed(8'h30) &&
              $signed(t) < $signed(h) && $signed(t) < $signed(o)) ? t + 8'h01
                                                                  : t;
    endfunction

    task automatic finish_test();
        $display("mismatches %0d, checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'hEB57C430));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 8'h33, 8'h00);
        `CHK(rd, {24'h0, OP_RST})
        apb(1'b0, 8'h67, 8'h00);
        `CHK(rd, {24'h0, THR_RST})
        apb(1'b0, 8'h00, 8'h00);
        `CHK({er, rd}, 33'h100000000)
        // Alert capture on remote 1 and local with remote 2 kept, then on remote 2.
        temp <= 24'($urandom);
        apb(1'b1, 8'h36, 8'h18);
        apb(1'b0, 8'h36, 8'h00);
        `CHK(rd[7:0], 8'h18)
        hot <= 1'b1;
        repeat (6) @(posedge clk);
        hot <= 1'b0;
        apb(1'b0, 8'h33, 8'h00);
        `CHK(rd[7:0], temp[0])
        apb(1'b0, 8'h34, 8'h00);
        `CHK(rd[7:0], temp[1])
        apb(1'b0, 8'h35, 8'h00);
        `CHK(rd[7:0], OP_RST)
        apb(1'b1, 8'h36, 8'h04);
        hot <= 1'b1;
        repeat (6) @(posedge clk);
        hot <= 1'b0;
        apb(1'b0, 8'h35, 8'h00);
        `CHK(rd[7:0], temp[2])
        // Threshold raise on remote 1, local disabled, remote 2 below start.
        temp <= {8'h10, 8'h28, 8'h28};
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, 8'(8'h4E + 2 * c), 8'h30);
            apb(1'b1, 8'(8'h33 + c), c == 0 ? 8'h23 : 8'h70);
            if (c < 2) apb(1'b1, 8'(8'h67 + c), 8'h20);
        end
        apb(1'b1, 8'h36, 8'hA0);
        e = '{8'h20, 8'h20, 8'h5A};
        hi = '{8'h7F, 8'h7F, 8'h7F};
        op = '{8'h23, 8'h70, 8'h70};
        for (int k = 0; k < 10; k++) begin
            if (k == 6) begin
                apb(1'b1, 8'h4F, 8'h24);
                apb(1'b1, 8'h33, 8'h7F);
                hi[0] = 8'h24;
                op[0] = 8'h7F;
            end
            lc <= 3'b111;
            @(posedge clk);
            lc <= 3'b000;
            e[0] = up(e[0], temp[0], hi[0], op[0]);
            e[2] = up(e[2], temp[2], hi[2], op[2]);
            @(posedge clk);
            `CHK(thr, {e[2],e[1],e[0]})
            `CHK(below, 3'b100)
        end
        apb(1'b1, 8'h67, 8'h80);
        repeat (2) @(posedge clk);
        `CHK(thr[0], 8'h81)
        // Offset-64 format moves remote 1 below its threshold.
        apb(1'b1, 8'h70, 8'h01);
        `CHK(below, 3'b101)
        // Step size and enable of every fan, slow option of fan 2 only.
        apb(1'b1, 8'h5D, 8'h08);
        for (int f = 0; f < 3; f++) begin
            for (int k = 0; k < 8; k++) begin
                ri = (f == 0) ? 8'h62 : 8'h63;
                sh = (f == 1) ? 4 : 0;
                tgt[f] <= 8'h00;
                apb(1'b1, ri, 8'h00);
                @(posedge clk);
                `CHK(duty[f], 8'h00)
                tg = 8'h40 + 8'($urandom_range(191));
                apb(1'b1, ri, 8'((8 + k) << sh));
                tgt[f] <= tg;
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (duty[f] === 8'h00 && n < 80);
                `CHK(duty[f], STEPS[k])
                if (k == 0) begin
                    n = 0;
                    do begin
                        @(posedge clk);
                        n++;
                    end while (duty[f] === 8'h01 && n < 80);
                    `CHK(n, (f == 1 ? 4 : 1) * TICK)
                end
            end
        end
        finish_test();
    end
endmodule // tb
`default_nettype wire
